// ---- logic/tkmc_pkg.sv ----
// Package of offsets, field positions, reset values and codes for the block
package tkmc_pkg;

  // ************************************************************
  // Register byte offsets on APB
  // ************************************************************
  localparam logic [11:0] TKMC_OFS_TRIM_LOW = 12'h000;
  localparam logic [11:0] TKMC_OFS_TRIM_HIGH = 12'h004;
  localparam logic [11:0] TKMC_OFS_CTRL_FIRST = 12'h008;
  localparam logic [11:0] TKMC_OFS_CTRL_SECOND = 12'h00c;
  localparam logic [11:0] TKMC_OFS_STATUS = 12'h010;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] TKMC_RST_TRIM_LOW = 8'h00;
  localparam logic [1:0] TKMC_RST_TRIM_HIGH = 2'h0;
  localparam logic [7:0] TKMC_RST_CTRL_FIRST = 8'h00;
  localparam logic [7:0] TKMC_RST_CTRL_SECOND = 8'h00;

  // ************************************************************
  // Field positions of the first control register
  // ************************************************************
  localparam int TKMC_C0_ROUTE_LSB = 6;
  localparam int TKMC_C0_DOUBLE = 5;
  localparam int TKMC_C0_FILTER = 4;
  localparam int TKMC_C0_HOPSRC = 3;
  localparam int TKMC_C0_HOP_LSB = 0;

  // ************************************************************
  // Field positions of the second control register
  // ************************************************************
  localparam int TKMC_C1_SLOTSRC = 7;
  localparam int TKMC_C1_UNUSED = 6;
  localparam int TKMC_C1_REFEN = 5;
  localparam int TKMC_C1_KEYEN = 4;
  localparam int TKMC_C1_KEYS_LSB = 0;

  // ************************************************************
  // Divider of the system clock for the slot clock
  // ************************************************************
  localparam int TKMC_SLOT_DIV = 4;
  localparam logic [1:0] TKMC_SLOT_DIV_LAST = 2'(TKMC_SLOT_DIV - 1);

  // Hop codes, frequency in kHz for the 1 MHz base
  typedef logic [10:0] tkmc_khz_t;

  // Nominal hop frequency of a code
  function automatic tkmc_khz_t tkmc_hop_khz(input logic [2:0] code);
    unique case (code)
      3'h0: tkmc_hop_khz = 11'd1020;
      3'h1: tkmc_hop_khz = 11'd1040;
      3'h2: tkmc_hop_khz = 11'd1059;
      3'h3: tkmc_hop_khz = 11'd1074;
      3'h4: tkmc_hop_khz = 11'd1085;
      3'h5: tkmc_hop_khz = 11'd1099;
      3'h6: tkmc_hop_khz = 11'd1111;
      3'h7: tkmc_hop_khz = 11'd1125;
    endcase
  endfunction

endpackage

// ---- logic/tkmc_osc_if.sv ----
// Interface carrying oscillator controls between the main module and mux
`timescale 1ns/1ns
interface tkmc_osc_if;
  logic [3:0] key_clk; // Key oscillator clocks masked by the pin enables
  logic [1:0] route; // Key selection
  logic dbl; // Frequency doubling enable
  logic run; // Key oscillator enable
  logic sel_clk; // Routed, gated, doubled key clock level
  modport ctrl (output route, dbl, run, key_clk, input sel_clk);
  modport mux (input route, dbl, run, key_clk, output sel_clk);
endinterface

// ---- logic/tkmc_key_mux.sv ----
// Key oscillator router with optional frequency doubling
`timescale 1ns/1ns
module tkmc_key_mux
  import tkmc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Oscillator controls
  tkmc_osc_if.mux osc
);

  // ************************************************************
  // Routing and doubling
  // ************************************************************
  logic picked; // Selected key clock level
  logic prev_q; // Last level, edge detect
  logic prev_d;
  logic out_q; // Output level
  logic out_d;

  // Select one of four key clocks
  always_comb begin
    picked = osc.key_clk[osc.route]; // RULE1
    prev_d = picked;
    out_d = 1'b0;
    if (!osc.run) begin
      out_d = 1'b0; // RULE7
    end else if (osc.dbl) begin
      out_d = picked ^ prev_q ? 1'b1 : 1'b0; // RULE2
    end else begin
      out_d = picked;
    end
  end

  // Register the routed clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      out_q <= out_d;
    end
  end

  assign osc.sel_clk = out_q;

  // Checks run on the APB clock and sleep in reset
  default clocking mux_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Output stays low while key oscillators are off
  key_off_low_a: assert property (!osc.run |=> !osc.sel_clk) // RULE7
    else $error("key clock active while disabled");

endmodule

// ---- logic/tkmc_top.sv ----
// Touch key module control registers and clock steering
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
// Overview of operation
// RULE1: Two-bit field routes one of four keys
// RULE2: Doubling bit doubles key oscillator frequency
// RULE3: Three-bit hop code picks eight frequencies
// RULE4: Ten-bit reference capacitor trim value held
// RULE5: Key enable gives pin to touch
// RULE6: Slot clock from reference or sysclk/4
// RULE7: Oscillators run only while enabled
// RULE8: Fields read/write, reset zero, unused zero
module tkmc_top
  import tkmc_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator inputs
  input wire logic [3:0] key_osc_in,
  input wire logic ref_osc_in,
  // Oscillator controls
  output logic ref_osc_run,
  output logic key_osc_run,
  output logic [9:0] ref_cap_trim_value,
  output logic [2:0] hop_frequency_code,
  output logic hop_control_source,
  output logic sense_filter_enable,
  output logic [10:0] hop_khz,
  // Pin function and measurement clocks
  output logic [3:0] touch_pin_sel,
  output logic key_count_clk,
  output logic slot_clk
);
  import tkmc_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] trim_low_q, trim_low_d; // Trim bits 7..0
  logic [1:0] trim_high_q, trim_high_d; // Trim bits 9..8
  logic [7:0] ctrl0_q, ctrl0_d; // First control register
  logic [7:0] ctrl1_q, ctrl1_d; // Second control register
  logic [1:0] div_q, div_d; // System clock divider
  logic slot_q, slot_d; // Slot clock level
  logic [31:0] rdata_d; // Read data next
  logic wr_en; // Write in access phase
  logic rd_en; // Read in setup phase
  logic hit; // Address decoded

  tkmc_osc_if osc ();

  // APB answers in the first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // ************************************************************
  // Register write path
  // ************************************************************
  always_comb begin
    trim_low_d = trim_low_q;
    trim_high_d = trim_high_q;
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    hit = 1'b1;
    unique case (paddr)
      TKMC_OFS_TRIM_LOW: begin
        if (wr_en) trim_low_d = pwdata[7:0]; // RULE4
      end
      TKMC_OFS_TRIM_HIGH: begin
        if (wr_en) trim_high_d = pwdata[1:0]; // RULE4
      end
      TKMC_OFS_CTRL_FIRST: begin
        if (wr_en) ctrl0_d = pwdata[7:0]; // RULE8
      end
      TKMC_OFS_CTRL_SECOND: begin
        if (wr_en) begin
          ctrl1_d = pwdata[7:0];
          ctrl1_d[TKMC_C1_UNUSED] = 1'b0; // RULE8
        end
      end
      TKMC_OFS_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data, registered in setup so it is ready at access
  always_comb begin
    rdata_d = prdata;
    if (rd_en) begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        TKMC_OFS_TRIM_LOW: rdata_d[7:0] = trim_low_q;
        TKMC_OFS_TRIM_HIGH: rdata_d[1:0] = trim_high_q; // RULE8
        TKMC_OFS_CTRL_FIRST: rdata_d[7:0] = ctrl0_q;
        TKMC_OFS_CTRL_SECOND: rdata_d[7:0] = ctrl1_q;
        TKMC_OFS_STATUS: rdata_d[2:0] = {slot_q, osc.sel_clk,
          ref_osc_run};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Unmapped addresses give an error at access
  assign pslverr = psel & penable & ~hit;

  // ************************************************************
  // Slot clock divider
  // ************************************************************
  always_comb begin
    div_d = (div_q == TKMC_SLOT_DIV_LAST) ? 2'h0 : div_q + 2'h1;
    if (ctrl1_q[TKMC_C1_SLOTSRC]) begin
      slot_d = div_q[1]; // RULE6
    end else begin
      slot_d = ref_osc_in & ctrl1_q[TKMC_C1_REFEN]; // RULE6 RULE7
    end
  end

  // Register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_low_q <= TKMC_RST_TRIM_LOW;
      trim_high_q <= TKMC_RST_TRIM_HIGH;
      ctrl0_q <= TKMC_RST_CTRL_FIRST;
      ctrl1_q <= TKMC_RST_CTRL_SECOND;
      div_q <= 2'h0;
      slot_q <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      trim_low_q <= trim_low_d;
      trim_high_q <= trim_high_d;
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      div_q <= div_d;
      slot_q <= slot_d;
      prdata <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ref_cap_trim_value = {trim_high_q, trim_low_q}; // RULE4
  assign ref_osc_run = ctrl1_q[TKMC_C1_REFEN]; // RULE7
  assign key_osc_run = ctrl1_q[TKMC_C1_KEYEN]; // RULE7
  assign touch_pin_sel = ctrl1_q[TKMC_C1_KEYS_LSB +: 4]; // RULE5
  assign hop_frequency_code = ctrl0_q[TKMC_C0_HOP_LSB +: 3];
  assign hop_khz = tkmc_hop_khz(hop_frequency_code); // RULE3
  assign hop_control_source = ctrl0_q[TKMC_C0_HOPSRC];
  assign sense_filter_enable = ctrl0_q[TKMC_C0_FILTER];
  assign slot_clk = slot_q;
  assign key_count_clk = osc.sel_clk;

  // Mux connections
  assign osc.key_clk = key_osc_in & touch_pin_sel; // RULE5
  assign osc.route = ctrl0_q[TKMC_C0_ROUTE_LSB +: 2]; // RULE1
  assign osc.dbl = ctrl0_q[TKMC_C0_DOUBLE]; // RULE2
  assign osc.run = key_osc_run;

  tkmc_key_mux u_mux (
    .pclk(pclk),
    .presetn(presetn),
    .osc(osc)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  // All checks run on the APB clock and sleep in reset
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Register write in the access phase of an APB transfer
  sequence apb_wr_s(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence

  // Divided slot source held from counter phase zero to three
  sequence slot_div_run_s;
    ctrl1_q[TKMC_C1_SLOTSRC] && div_q == 2'h0 ##1
      ctrl1_q[TKMC_C1_SLOTSRC] [*3];
  endsequence

  // First control register takes the written byte
  ctrl_write_a: assert property (apb_wr_s(TKMC_OFS_CTRL_FIRST) // RULE8
    |=> ctrl0_q == $past(pwdata[7:0]))
    else $error("first control write lost");
  // Unused control bit never holds a one
  unused_zero_a: assert property (!ctrl1_q[TKMC_C1_UNUSED]) // RULE8
    else $error("unused control bit set");
  // High trim bits follow the written word
  trim_join_a: assert property (apb_wr_s(TKMC_OFS_TRIM_HIGH) // RULE4
    |=> ref_cap_trim_value[9:8] == $past(pwdata[1:0]))
    else $error("trim high bits wrong");
  // Pin functions follow the written key enables
  pin_sel_a: assert property (apb_wr_s(TKMC_OFS_CTRL_SECOND) // RULE5
    |=> touch_pin_sel == $past(pwdata[3:0]))
    else $error("pin select mismatch");
  // Slot clock is high once the divider has passed its upper half
  slot_div_a: assert property (slot_div_run_s |=> slot_q) // RULE6
    else $error("slot divider phase wrong");
  // A stopped reference oscillator gives no slot clock when it is the slot source
  ref_off_a: assert property (!ref_osc_run // RULE7
    && !ctrl1_q[TKMC_C1_SLOTSRC] |=> !slot_q)
    else $error("slot clock from stopped reference");
  // Last hop code decodes to the top frequency
  hop_end_a: assert property (hop_frequency_code == 3'h7 // RULE3
    |-> hop_khz == 11'd1125)
    else $error("hop code decode wrong");
  // Routed key level shows on the count clock one cycle later
  route_a: assert property (key_osc_run && !osc.dbl // RULE1
    && $stable(osc.route) |=> key_count_clk
      == $past(osc.key_clk[osc.route]))
    else $error("key route wrong");

endmodule

// ---- testbench/tkmc_bench.sv ----
// Self-checking bench for the touch key module control block
`timescale 1ns/1ns
module tkmc_bench;
  import tkmc_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic pclk = 1'b0; // System clock
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0, prdata; // APB data
  logic pready, pslverr; // APB answer
  logic [3:0] key_osc_in = 4'h0; // Key oscillator levels
  logic ref_osc_in = 1'b0; // Reference oscillator level
  logic ref_osc_run, key_osc_run, hop_control_source, sense_filter_enable;
  logic [9:0] ref_cap_trim_value; // Capacitor trim
  logic [2:0] hop_frequency_code; // Hop code
  logic [10:0] hop_khz; // Hop frequency
  logic [3:0] touch_pin_sel; // Pin function
  logic key_count_clk, slot_clk; // Measurement clocks
  int err_count = 0; // Mismatches
  int checks_done = 0; // Comparisons
  logic [10:0] khz_tab [8] = '{11'd1020, 11'd1040, 11'd1059, 11'd1074,
    11'd1085, 11'd1099, 11'd1111, 11'd1125}; // Expected hop table
  logic [31:0] rd_v; // Read data
  logic rd_e; // Read error flag
  int n; // Edge count

  always #10 pclk = ~pclk; // 50 MHz

  tkmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_osc_in(key_osc_in), .ref_osc_in(ref_osc_in),
    .ref_osc_run(ref_osc_run), .key_osc_run(key_osc_run),
    .ref_cap_trim_value(ref_cap_trim_value),
    .hop_frequency_code(hop_frequency_code),
    .hop_control_source(hop_control_source),
    .sense_filter_enable(sense_filter_enable), .hop_khz(hop_khz),
    .touch_pin_sel(touch_pin_sel), .key_count_clk(key_count_clk),
    .slot_clk(slot_clk));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer, waits for pready with a bound
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h1, 32'h0, "pready timeout");
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let registers written at the access edge settle before callers look
    @(posedge pclk);
  endtask

  // Read and compare
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp, "read data");
  endtask

  // Count rising edges over 40 cycles, toggling key 0 when asked
  task automatic cnt(input logic slot, output int e);
    logic p, c;
    e = 0;
    @(negedge pclk);
    p = slot ? slot_clk : key_count_clk;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (!slot && i < 32 && i % 4 == 0) key_osc_in[0] <= ~key_osc_in[0];
      @(negedge pclk);
      c = slot ? slot_clk : key_count_clk;
      if (c === 1'b1 && p === 1'b0) e++;
      p = c;
    end
  endtask

  // Closing report
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    #400000;
    err_count++;
    test_done;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and status
    for (int a = 0; a < 5; a++) rc(12'(a * 4), 32'h0);
    // All ones (second control 6f), unused bits read zero
    apb(1'b1, TKMC_OFS_TRIM_LOW, 32'hffffffff);
    apb(1'b1, TKMC_OFS_TRIM_HIGH, 32'hffffffff);
    apb(1'b1, TKMC_OFS_CTRL_FIRST, 32'hffffffff);
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h0000006f);
    rc(TKMC_OFS_TRIM_LOW, 32'hff);
    rc(TKMC_OFS_TRIM_HIGH, 32'h3);
    rc(TKMC_OFS_CTRL_FIRST, 32'hff);
    rc(TKMC_OFS_CTRL_SECOND, 32'h2f);
    chk(32'(ref_cap_trim_value), 32'h3ff, "trim");
    chk(32'(touch_pin_sel), 32'hf, "pins");
    chk(32'({ref_osc_run, key_osc_run, sense_filter_enable,
      hop_control_source}), 32'hb, "run bits");
    // Split trim halves are independent
    apb(1'b1, TKMC_OFS_TRIM_LOW, 32'h5a);
    apb(1'b1, TKMC_OFS_TRIM_HIGH, 32'h2);
    chk(32'(ref_cap_trim_value), 32'h25a, "trim split");
    // Unmapped address refused
    apb(1'b1, 12'h014, 32'hff);
    chk(32'(rd_e), 32'h1, "slverr");
    rc(12'h014, 32'h0);
    // Every hop code
    for (int h = 0; h < 8; h++) begin
      apb(1'b1, TKMC_OFS_CTRL_FIRST, 32'(h));
      chk(32'(hop_frequency_code), 32'(h), "hop code");
      chk(32'(hop_khz), 32'(khz_tab[h]), "hop khz");
    end
    // Every key route, selected key only counts
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h1f);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, TKMC_OFS_CTRL_FIRST, 32'(r << 6));
      key_osc_in <= 4'(1 << r);
      repeat (4) @(posedge pclk);
      chk(32'(key_count_clk), 32'h1, "route on");
      key_osc_in <= ~4'(1 << r);
      repeat (4) @(posedge pclk);
      chk(32'(key_count_clk), 32'h0, "route off");
    end
    key_osc_in <= 4'hf;
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h17);
    repeat (4) @(posedge pclk);
    chk(32'(key_count_clk), 32'h0, "pin off");
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h0f);
    repeat (4) @(posedge pclk);
    chk(32'(key_count_clk), 32'h0, "key osc off");
    // Normal and doubled key clock on key 0
    key_osc_in <= 4'h0;
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h1f);
    apb(1'b1, TKMC_OFS_CTRL_FIRST, 32'h00);
    cnt(1'b0, n);
    chk(32'(n), 32'd4, "normal edges");
    apb(1'b1, TKMC_OFS_CTRL_FIRST, 32'h20);
    cnt(1'b0, n);
    chk(32'(n), 32'd8, "doubled edges");
    // Slot clock from divided system clock
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h80);
    cnt(1'b1, n);
    chk(32'(n), 32'd10, "slot div");
    // Slot clock from reference oscillator
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h20);
    ref_osc_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(slot_clk), 32'h1, "slot ref");
    rc(TKMC_OFS_STATUS, 32'h5);
    apb(1'b1, TKMC_OFS_CTRL_SECOND, 32'h00);
    repeat (4) @(posedge pclk);
    chk(32'(slot_clk), 32'h0, "ref off");
    test_done;
  end
endmodule
